// ---- design/timer_b_mode_event_capture_regs.sv ----
// Purpose: 16-bit capture/compare timer core with APB register file
// Assumes: event_in and debug_halt come from logic on sys_clk
// Notes:   APB answer takes one wait state; effects land at the completing edge
`timescale 1ns/100ps
module timer_b_mode_event_capture_regs (
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rstn,
   // APB slave
   input  wire timer_b_unit_pkg::apb_req_t apb_req,
   output      timer_b_unit_pkg::apb_rsp_t apb_rsp,
   // Event network and debug
   input  wire logic                       event_in,
   input  wire logic                       debug_halt,
   // Interrupt
   output      logic                       irq
);
   import timer_b_unit_pkg::*;

   timer_state_t st_r;
   timer_state_t st_nxt;

   logic       halted;
   logic       src;
   logic       rise;
   logic       fall;
   logic       act;
   logic       sel_edge;
   logic       opp_edge;
   logic       tick;
   logic       at_top;
   logic       set_flag;
   logic       clr_flag;
   logic       prep;
   logic       done;
   logic       mapped;
   logic       capture_mode;
   logic [3:0] idx;
   logic       bus_wr;
   logic       bus_rd;

   assign halted   = debug_halt & ~st_r.halt_run_allow;                  // [RULE18]
   assign src      = st_r.filt_en ? st_r.filt_val : event_in;             // [RULE2]
   assign rise     = src & ~st_r.ev_prev;
   assign fall     = ~src & st_r.ev_prev;
   assign act      = st_r.ctrl_en & st_r.ev_en & ~halted;                 // [RULE15] [RULE18]
   assign sel_edge = act & (st_r.edge_pol ? fall : rise);
   assign opp_edge = act & (st_r.edge_pol ? rise : fall);
   assign tick     = st_r.ctrl_en & ~halted;
   assign at_top   = st_r.count == st_r.compare;                          // [RULE22]
   assign idx      = apb_req.paddr[5:2];
   assign mapped   = (apb_req.paddr[ADDR_W-1:6] == '0) && (apb_req.paddr[1:0] == 2'h0) &&
                     (idx <= IDX_COMPARE_HI) && (idx != 4'h2) && (idx != 4'h3);
   assign prep     = apb_req.psel & apb_req.penable & ~st_r.rsp.pready;
   assign done     = apb_req.psel & apb_req.penable & st_r.rsp.pready & ~st_r.rsp.pslverr;
   assign bus_wr   = done & apb_req.pwrite;
   assign bus_rd   = done & ~apb_req.pwrite;
   assign capture_mode = (st_r.mode == MODE_EVENT_CAP) || (st_r.mode == MODE_FREQ) ||
                         (st_r.mode == MODE_PULSE) || (st_r.mode == MODE_FREQ_PW);

   function automatic logic [31:0] read_mux(input timer_state_t s, input logic [3:0] i);
      logic [7:0] b;
      b = BYTE_ZERO;
      case (i)
         IDX_CTRL_A:         b[BIT_ENABLE] = s.ctrl_en;
         IDX_CONTROL_SECOND: b[2:0] = s.mode;
         IDX_EVENT_CONTROL: begin
            b[BIT_FILTER] = s.filt_en;
            b[BIT_EDGE]   = s.edge_pol;
            b[BIT_EV_EN]  = s.ev_en;
         end
         IDX_IRQ_ENABLE:     b[BIT_IRQ] = s.irq_en;
         IDX_IRQ_FLAG:       b[BIT_IRQ] = s.flag;
         IDX_RUN_STATE:      b[BIT_RUN] = s.running;                      // [RULE17]
         IDX_DEBUG_HALT:     b[BIT_HALT_OK] = s.halt_run_allow;
         IDX_STAGING:        b = s.staging;                               // [RULE19]
         IDX_COUNT_LO:       b = s.count[7:0];                            // [RULE20]
         IDX_COUNT_HI:       b = s.staging;                               // [RULE25]
         IDX_COMPARE_LO:     b = s.compare[7:0];
         // PWM bytes are independent, so the high byte bypasses staging
         IDX_COMPARE_HI:     b = (s.mode == MODE_PWM8) ? s.compare[15:8] : s.staging; // [RULE23]
         default:            b = BYTE_ZERO;
      endcase
      return {24'h000000, b};
   endfunction : read_mux

   always_comb begin
      st_nxt = st_r;
      set_flag = 1'b0;
      clr_flag = 1'b0;
      st_nxt.rsp.pready  = 1'b0;
      st_nxt.rsp.pslverr = 1'b0;
      // Noise canceller: value moves only after four equal samples
      st_nxt.filt_hist = {st_r.filt_hist[2:0], event_in};
      if (st_r.filt_hist == FILT_ALL_ONE) begin
         st_nxt.filt_val = 1'b1;                                          // [RULE24]
      end else if (st_r.filt_hist == FILT_ALL_ZERO) begin
         st_nxt.filt_val = 1'b0;                                          // [RULE24]
      end
      st_nxt.ev_prev = src;

      if (!st_r.ctrl_en) begin
         st_nxt.running = 1'b0;
         st_nxt.phase   = FP_WAIT;
      end else if (tick) begin
         case (st_r.mode)                                                 // [RULE1]
            MODE_PERIODIC: begin
               st_nxt.running = 1'b1;
               if (at_top) begin
                  st_nxt.count = COUNT_RESET;
                  set_flag = 1'b1;                                        // [RULE11]
               end else begin
                  st_nxt.count = st_r.count + COUNT_ONE;
               end
            end
            MODE_TIMEOUT: begin
               if (st_r.running) begin
                  if (at_top) begin
                     st_nxt.count = COUNT_RESET;
                     set_flag = 1'b1;                                     // [RULE11]
                  end else begin
                     st_nxt.count = st_r.count + COUNT_ONE;
                  end
               end
               if (sel_edge) begin
                  st_nxt.running = 1'b1;                                  // [RULE3]
                  st_nxt.count   = COUNT_RESET;
               end else if (opp_edge) begin
                  st_nxt.running = 1'b0;                                  // [RULE3]
               end
            end
            MODE_EVENT_CAP: begin
               st_nxt.running = 1'b1;
               st_nxt.count   = st_r.count + COUNT_ONE;
               if (sel_edge) begin
                  st_nxt.compare = st_r.count;                            // [RULE8]
                  set_flag = 1'b1;                                        // [RULE8]
               end
            end
            MODE_FREQ: begin
               st_nxt.running = 1'b1;
               if (sel_edge) begin
                  st_nxt.compare = st_r.count;                            // [RULE4]
                  st_nxt.count   = COUNT_RESET;                           // [RULE4]
                  set_flag = 1'b1;                                        // [RULE9]
               end else begin
                  st_nxt.count = st_r.count + COUNT_ONE;
               end
            end
            MODE_PULSE: begin
               st_nxt.running = 1'b1;
               if (sel_edge) begin
                  st_nxt.count = COUNT_RESET;                             // [RULE5]
               end else begin
                  st_nxt.count = st_r.count + COUNT_ONE;
               end
               if (opp_edge) begin
                  st_nxt.compare = st_r.count;                            // [RULE5]
                  set_flag = 1'b1;                                        // [RULE10]
               end
            end
            MODE_FREQ_PW: begin
               if (st_r.running) begin
                  st_nxt.count = st_r.count + COUNT_ONE;
               end
               case (st_r.phase)
                  FP_WAIT: begin
                     if (sel_edge) begin
                        st_nxt.count   = COUNT_RESET;                     // [RULE6]
                        st_nxt.running = 1'b1;
                        st_nxt.phase   = FP_FIRST;
                     end
                  end
                  FP_FIRST: begin
                     if (opp_edge) begin
                        st_nxt.compare = st_r.count;                      // [RULE6]
                        st_nxt.phase   = FP_SECOND;
                     end
                  end
                  FP_SECOND: begin
                     if (sel_edge) begin
                        st_nxt.running = 1'b0;                            // [RULE6]
                        st_nxt.count   = st_r.count;
                        st_nxt.phase   = FP_WAIT;
                        set_flag = 1'b1;                                  // [RULE7]
                     end
                  end
                  default: st_nxt.phase = FP_WAIT;
               endcase
            end
            MODE_SINGLE: begin
               if (st_r.running) begin
                  if (at_top) begin
                     st_nxt.running = 1'b0;
                     set_flag = 1'b1;                                     // [RULE12]
                  end else begin
                     st_nxt.count = st_r.count + COUNT_ONE;
                  end
               end else if (act && (rise || (st_r.edge_pol && fall))) begin
                  st_nxt.running = 1'b1;                                  // [RULE12]
                  st_nxt.count   = COUNT_RESET;
               end
            end
            MODE_PWM8: begin
               // Low compare byte is the period, high byte the match point
               st_nxt.running = 1'b1;
               if (st_r.count[7:0] == st_r.compare[7:0]) begin
                  st_nxt.count = COUNT_RESET;                             // [RULE23]
               end else begin
                  st_nxt.count = {BYTE_ZERO, st_r.count[7:0] + 8'h01};
               end
               if (st_r.count[7:0] == st_r.compare[15:8]) begin
                  set_flag = 1'b1;                                        // [RULE13]
               end
            end
            default: st_nxt.running = 1'b0;
         endcase
      end

      // APB: answer prepared one cycle ahead, effects at the completing edge
      if (prep) begin
         st_nxt.rsp.pready  = 1'b1;
         st_nxt.rsp.pslverr = ~mapped;
         st_nxt.rsp.prdata  = mapped ? read_mux(st_r, idx) : 32'h00000000;
      end
      if (bus_wr) begin
         // Bus writes come last so they override the internal update, except a flag clear, which a new event beats
         case (idx)
            IDX_CTRL_A: begin
               st_nxt.ctrl_en = apb_req.pwdata[BIT_ENABLE];
               st_nxt.running = st_nxt.running & apb_req.pwdata[BIT_ENABLE];
            end
            IDX_CONTROL_SECOND: st_nxt.mode = count_mode_sel_t'(apb_req.pwdata[2:0]);
            IDX_EVENT_CONTROL: begin
               st_nxt.filt_en  = apb_req.pwdata[BIT_FILTER];
               st_nxt.edge_pol = apb_req.pwdata[BIT_EDGE];
               st_nxt.ev_en    = apb_req.pwdata[BIT_EV_EN];
            end
            IDX_IRQ_ENABLE:     st_nxt.irq_en = apb_req.pwdata[BIT_IRQ];
            IDX_IRQ_FLAG:       clr_flag = apb_req.pwdata[BIT_IRQ];      // [RULE14]
            IDX_DEBUG_HALT:     st_nxt.halt_run_allow = apb_req.pwdata[BIT_HALT_OK];
            IDX_STAGING:        st_nxt.staging = apb_req.pwdata[7:0];    // [RULE19]
            IDX_COUNT_LO:       st_nxt.staging = apb_req.pwdata[7:0];    // [RULE25]
            IDX_COUNT_HI:       st_nxt.count = {apb_req.pwdata[7:0], st_r.staging}; // [RULE21]
            IDX_COMPARE_LO: begin
               if (st_r.mode == MODE_PWM8) begin
                  st_nxt.compare[7:0] = apb_req.pwdata[7:0];              // [RULE23]
               end else begin
                  st_nxt.staging = apb_req.pwdata[7:0];                   // [RULE25]
               end
            end
            IDX_COMPARE_HI: begin
               if (st_r.mode == MODE_PWM8) begin
                  st_nxt.compare[15:8] = apb_req.pwdata[7:0];             // [RULE23]
               end else begin
                  st_nxt.compare = {apb_req.pwdata[7:0], st_r.staging};   // [RULE25]
               end
            end
            default: st_nxt.staging = st_r.staging;                       // [RULE17]
         endcase
      end
      if (bus_rd) begin
         if (idx == IDX_COUNT_LO) begin
            st_nxt.staging = st_r.count[15:8];                            // [RULE25]
         end
         if ((idx == IDX_COMPARE_LO) && (st_r.mode != MODE_PWM8)) begin
            st_nxt.staging = st_r.compare[15:8];                          // [RULE25]
         end
         if ((idx == IDX_COMPARE_LO) && capture_mode) begin
            clr_flag = 1'b1;                                              // [RULE14]
         end
      end
      // A new event in the clearing cycle is kept
      st_nxt.flag = (st_r.flag & ~clr_flag) | set_flag;
      st_nxt.irq  = st_nxt.flag & st_nxt.irq_en;                          // [RULE16]
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
         st_r.phase <= FP_WAIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign apb_rsp = st_r.rsp;
   assign irq     = st_r.irq;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_irq_gate;
      irq |-> (st_r.flag && st_r.irq_en);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without flag and enable"); // [RULE16]

   property p_periodic_top;
      (tick && st_r.mode == MODE_PERIODIC && at_top && !bus_wr) |=>
         (st_r.count == COUNT_RESET && st_r.flag);
   endproperty
   a_periodic_top: assert property (p_periodic_top) else $error("periodic top missed"); // [RULE11]

   property p_freq_capture;
      (st_r.mode == MODE_FREQ && sel_edge && !bus_wr) |=>
         (st_r.compare == $past(st_r.count) && st_r.count == COUNT_RESET && st_r.flag);
   endproperty
   a_freq_capture: assert property (p_freq_capture) else $error("frequency capture wrong"); // [RULE4]

   property p_events_off;
      (!st_r.ev_en && st_r.mode == MODE_EVENT_CAP && !bus_wr) |=> $stable(st_r.compare);
   endproperty
   a_events_off: assert property (p_events_off) else $error("event acted while disabled"); // [RULE15]

   property p_halt_freeze;
      (halted && !bus_wr) |=> ($stable(st_r.count) && $stable(st_r.running));
   endproperty
   a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved in debug halt"); // [RULE18]

   property p_count_commit;
      (bus_wr && idx == IDX_COUNT_HI) |=>
         (st_r.count == {$past(apb_req.pwdata[7:0]), $past(st_r.staging)});
   endproperty
   a_count_commit: assert property (p_count_commit) else $error("counter write lost"); // [RULE21]

   property p_flag_clear;
      (bus_wr && idx == IDX_IRQ_FLAG && apb_req.pwdata[BIT_IRQ] && !set_flag) |=> !st_r.flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // [RULE14]

   property p_pwm_flag;
      (tick && st_r.mode == MODE_PWM8 && st_r.count[7:0] == st_r.compare[15:8]) |=> st_r.flag;
   endproperty
   a_pwm_flag: assert property (p_pwm_flag) else $error("pwm match flag missed"); // [RULE13]

   property p_filter_accept;
      (st_r.filt_hist == FILT_ALL_ONE) |=> st_r.filt_val;
   endproperty
   a_filter_accept: assert property (p_filter_accept) else $error("filter did not accept"); // [RULE24]

   property p_run_read;
      (prep && mapped && !apb_req.pwrite && idx == IDX_RUN_STATE) |=>
         (apb_rsp.prdata[BIT_RUN] == $past(st_r.running) && apb_rsp.pready);
   endproperty
   a_run_read: assert property (p_run_read) else $error("run bit read wrong"); // [RULE17]

   property p_timeout_start;
      (st_r.mode == MODE_TIMEOUT && sel_edge && !bus_wr) |=>
         (st_r.running && st_r.count == COUNT_RESET);
   endproperty
   a_timeout_start: assert property (p_timeout_start) else $error("no timeout start"); // [RULE3]

   property p_pulse_capture;
      (st_r.mode == MODE_PULSE && opp_edge && !bus_wr) |=>
         (st_r.compare == $past(st_r.count) && st_r.flag);
   endproperty
   a_pulse_capture: assert property (p_pulse_capture) else $error("no pulse capture"); // [RULE10]

   property p_fp_stop;
      (st_r.mode == MODE_FREQ_PW && st_r.phase == FP_SECOND && sel_edge && !bus_wr) |=>
         (!st_r.running && st_r.flag);
   endproperty
   a_fp_stop: assert property (p_fp_stop) else $error("combined mode did not stop"); // [RULE7]

   property p_single_stop;
      (tick && st_r.mode == MODE_SINGLE && st_r.running && at_top && !bus_wr) |=>
         (!st_r.running && st_r.flag);
   endproperty
   a_single_stop: assert property (p_single_stop) else $error("single shot overran"); // [RULE12]

   property p_cap_clear;
      (bus_rd && idx == IDX_COMPARE_LO && capture_mode && !set_flag) |=> !st_r.flag;
   endproperty
   a_cap_clear: assert property (p_cap_clear) else $error("read kept flag"); // [RULE14]
endmodule : timer_b_mode_event_capture_regs

// ---- design/timer_b_unit_pkg.sv ----
// Purpose: Constants and types for the timer_b_unit mode, event and register logic
// Assumes: APB slave, 32-bit data, byte address = 4 x register index
// Notes:   Narrow registers sit in the low bits of the word
// Functional notes
// RULE1 - Three-bit count_mode_sel picks one of eight counting modes 0x0..0x7
// RULE2 - Filter bit routes event input through noise canceller before edge detection
// RULE3 - Timeout mode: polarity 0 rise starts, fall stops; polarity 1 swapped
// RULE4 - Frequency mode: selected edge captures, reinitialises counter, sets flag
// RULE5 - Pulse width mode: one edge reinitialises, opposite edge captures and sets flag
// RULE6 - Combined mode: first edge init, opposite edge capture, second edge stop
// RULE7 - Combined mode sets flag on second selected edge when counter stops
// RULE8 - Capture-on-event: accepted event loads capture register and sets flag
// RULE9 - Frequency mode flag set on the edge that captures and reinitialises
// RULE10 - Pulse width flag set on capturing edge, previous edge having reinitialised
// RULE11 - Periodic and timeout modes set flag when counter reaches top
// RULE12 - Single shot sets flag at top; polarity 1 any edge starts, 0 rising only
// RULE13 - PWM mode flag at compare high byte; events ignored in PWM and periodic
// RULE14 - Flag clears on write of one, and on capture read in capture modes
// RULE15 - Event input enable gates all event actions
// RULE16 - Interrupt request only when enable and flag are both set
// RULE17 - Run bit shows counter running and ignores writes
// RULE18 - Halt run allow 0 halts timer and ignores events in debug break
// RULE19 - One shared 8-bit staging register, itself readable and writable
// RULE20 - Counter low byte at base, high byte at base plus one
// RULE21 - Bus write to counter wins over coincident internal update
// RULE22 - Compare value is top in periodic, timeout and single shot modes
// RULE23 - PWM mode treats compare bytes as two independent registers
// RULE24 - Filter accepts input after four equal samples
// RULE25 - Low byte written first into staging, high commits; low read latches high
package timer_b_unit_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_CTRL_A        = 4'h0;
   localparam logic [3:0] IDX_CONTROL_SECOND = 4'h1;
   localparam logic [3:0] IDX_EVENT_CONTROL = 4'h4;
   localparam logic [3:0] IDX_IRQ_ENABLE    = 4'h5;
   localparam logic [3:0] IDX_IRQ_FLAG      = 4'h6;
   localparam logic [3:0] IDX_RUN_STATE     = 4'h7;
   localparam logic [3:0] IDX_DEBUG_HALT    = 4'h8;
   localparam logic [3:0] IDX_STAGING       = 4'h9;
   localparam logic [3:0] IDX_COUNT_LO      = 4'ha;
   localparam logic [3:0] IDX_COUNT_HI      = 4'hb;
   localparam logic [3:0] IDX_COMPARE_LO    = 4'hc;
   localparam logic [3:0] IDX_COMPARE_HI    = 4'hd;
   localparam int ADDR_W = 12;
   // Field positions
   localparam int BIT_ENABLE  = 0;
   localparam int BIT_FILTER  = 6;
   localparam int BIT_EDGE    = 4;
   localparam int BIT_EV_EN   = 0;
   localparam int BIT_IRQ     = 0;
   localparam int BIT_RUN     = 0;
   localparam int BIT_HALT_OK = 0;
   localparam logic [3:0] FILT_ALL_ONE  = 4'hf;
   localparam logic [3:0] FILT_ALL_ZERO = 4'h0;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;
   localparam logic [15:0] COUNT_RESET  = 16'h0000;
   localparam logic [15:0] COUNT_ONE    = 16'h0001;

   typedef enum logic [2:0] {
      MODE_PERIODIC = 3'h0,
      MODE_TIMEOUT  = 3'h1,
      MODE_EVENT_CAP = 3'h2,
      MODE_FREQ     = 3'h3,
      MODE_PULSE    = 3'h4,
      MODE_FREQ_PW  = 3'h5,
      MODE_SINGLE   = 3'h6,
      MODE_PWM8     = 3'h7
   } count_mode_sel_t;

   typedef enum logic [2:0] {
      FP_WAIT  = 3'b001,
      FP_FIRST = 3'b010,
      FP_SECOND = 3'b100
   } fp_phase_t;

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [31:0]       pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic            ctrl_en;
      count_mode_sel_t mode;
      logic            filt_en;
      logic            edge_pol;
      logic            ev_en;
      logic            irq_en;
      logic            flag;
      logic            halt_run_allow;
      logic [7:0]      staging;
      logic [15:0]     count;
      logic [15:0]     compare;
      logic            running;
      fp_phase_t       phase;
      logic [3:0]      filt_hist;
      logic            filt_val;
      logic            ev_prev;
      apb_rsp_t        rsp;
      logic            irq;
   } timer_state_t;
endpackage : timer_b_unit_pkg

// ---- bench/event_net_model.sv ----
// Purpose: Event network and debug break source seen by the timer
// Assumes: Requests from the bench are levels on sys_clk
// Notes:   Outputs come from flops, as the real event routing does
`timescale 1ns/100ps
module event_net_model (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // Requests from the bench
   input  wire logic ev_level,
   input  wire logic halt_req,
   // Towards the timer
   output      logic event_in,
   output      logic debug_halt
);
   // Levels change only after an edge, so every change lasts at least a cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         event_in   <= 1'b0;
         debug_halt <= 1'b0;
      end else begin
         event_in   <= ev_level;
         debug_halt <= halt_req;
      end
   end
endmodule : event_net_model

// ---- bench/timer_b_mode_event_capture_regs_tb.sv ----
// Purpose: Self-checking bench for the timer register and event logic
// Assumes: APB answer arrives when pready is seen high; no cycle count assumed
// Notes:   Captured counts are not predicted, only flag, irq and register effects
`timescale 1ns/100ps
module timer_b_mode_event_capture_regs_tb;
   import timer_b_unit_pkg::*;
   logic        sys_clk;
   logic        rstn;
   apb_req_t    req;
   apb_rsp_t    rsp;
   logic        ev_level;
   logic        halt_req;
   logic        event_in;
   logic        debug_halt;
   logic        irq;
   logic [31:0] rd;
   logic [31:0] snap;
   int          failures;
   int          checked;

   timer_b_mode_event_capture_regs u_dut (.sys_clk(sys_clk), .rstn(rstn), .apb_req(req),
      .apb_rsp(rsp), .event_in(event_in), .debug_halt(debug_halt), .irq(irq));
   event_net_model u_net (.sys_clk(sys_clk), .rstn(rstn), .ev_level(ev_level),
      .halt_req(halt_req), .event_in(event_in), .debug_halt(debug_halt));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task complete_run;
      if (failures == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Request held until pready is seen high at a rising edge
   task apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd, input logic err);
      @(posedge sys_clk);
      req.paddr  <= {6'h00, idx, 2'b00};
      req.pwrite <= wr;
      req.pwdata <= {24'h000000, wd};
      req.psel   <= 1'b1;
      @(posedge sys_clk);
      req.penable <= 1'b1;
      do @(posedge sys_clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      chk({31'h0, rsp.pslverr}, {31'h0, err});
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task wr(input logic [3:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 1'b0);
   endtask : wr

   task rdc(input logic [3:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00, 1'b0);
      chk(rd, exp);
   endtask : rdc

   task irqc(input logic exp);
      @(negedge sys_clk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask : irqc

   task ev(input logic lvl, input int hold);
      @(posedge sys_clk);
      ev_level <= lvl;
      repeat (hold) @(posedge sys_clk);
   endtask : ev

   initial begin
      failures = 0;
      checked  = 0;
      rstn     = 1'b0;
      ev_level = 1'b0;
      halt_req = 1'b0;
      req      = '0;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      for (int i = 4; i <= 10; i++) rdc(4'(i), 32'h0);
      apb(1'b0, 4'h2, 8'h00, 1'b1);
      wr(IDX_STAGING, 8'h5a);
      rdc(IDX_STAGING, 32'h5a);
      wr(IDX_COUNT_LO, 8'h34);
      wr(IDX_COUNT_HI, 8'h12);
      rdc(IDX_COUNT_LO, 32'h34);
      rdc(IDX_STAGING, 32'h12);
      wr(IDX_RUN_STATE, 8'h01);
      rdc(IDX_RUN_STATE, 32'h0);
      for (int m = 7; m >= 0; m--) begin
         wr(IDX_CONTROL_SECOND, 8'(m));
         rdc(IDX_CONTROL_SECOND, 32'(m));
      end
      // Periodic mode with a short top, then a frozen count under debug break
      wr(IDX_COMPARE_LO, 8'h10);
      wr(IDX_COMPARE_HI, 8'h00);
      wr(IDX_COUNT_LO, 8'h00);
      wr(IDX_COUNT_HI, 8'h00);
      wr(IDX_IRQ_ENABLE, 8'h01);
      wr(IDX_CTRL_A, 8'h01);
      repeat (40) @(posedge sys_clk);
      rdc(IDX_IRQ_FLAG, 32'h1);
      rdc(IDX_RUN_STATE, 32'h1);
      irqc(1'b1);
      halt_req <= 1'b1;
      apb(1'b0, IDX_COUNT_LO, 8'h00, 1'b0);
      snap = rd;
      repeat (10) @(posedge sys_clk);
      rdc(IDX_COUNT_LO, snap);
      halt_req <= 1'b0;
      wr(IDX_CTRL_A, 8'h00);
      wr(IDX_IRQ_FLAG, 8'h01);
      rdc(IDX_IRQ_FLAG, 32'h0);
      rdc(IDX_RUN_STATE, 32'h0);
      irqc(1'b0);
      // Capture on event, then the same event with the input gated off
      wr(IDX_CONTROL_SECOND, 8'h02);
      wr(IDX_EVENT_CONTROL, 8'h01);
      wr(IDX_CTRL_A, 8'h01);
      ev(1'b1, 3);
      ev(1'b0, 3);
      rdc(IDX_IRQ_FLAG, 32'h1);
      irqc(1'b1);
      apb(1'b0, IDX_COMPARE_LO, 8'h00, 1'b0);
      rdc(IDX_IRQ_FLAG, 32'h0);
      wr(IDX_EVENT_CONTROL, 8'h00);
      ev(1'b1, 3);
      ev(1'b0, 3);
      rdc(IDX_IRQ_FLAG, 32'h0);
      // Frequency mode on the falling edge only
      wr(IDX_CONTROL_SECOND, 8'h03);
      wr(IDX_EVENT_CONTROL, 8'h11);
      ev(1'b1, 3);
      rdc(IDX_IRQ_FLAG, 32'h0);
      ev(1'b0, 3);
      rdc(IDX_IRQ_FLAG, 32'h1);
      apb(1'b0, IDX_COMPARE_LO, 8'h00, 1'b0);
      // Filtered input: a short glitch is dropped, a steady level is taken
      wr(IDX_CONTROL_SECOND, 8'h02);
      wr(IDX_EVENT_CONTROL, 8'h41);
      ev(1'b1, 2);
      ev(1'b0, 10);
      rdc(IDX_IRQ_FLAG, 32'h0);
      ev(1'b1, 8);
      ev(1'b0, 8);
      rdc(IDX_IRQ_FLAG, 32'h1);
      wr(IDX_IRQ_FLAG, 8'h01);
      wr(IDX_CONTROL_SECOND, 8'h04);
      wr(IDX_EVENT_CONTROL, 8'h01);
      ev(1'b1, 3);
      rdc(IDX_IRQ_FLAG, 32'h0);
      ev(1'b0, 3);
      rdc(IDX_IRQ_FLAG, 32'h1);
      apb(1'b0, IDX_COMPARE_LO, 8'h00, 1'b0);
      wr(IDX_CONTROL_SECOND, 8'h05);
      ev(1'b1, 3);
      ev(1'b0, 3);
      rdc(IDX_IRQ_FLAG, 32'h0);
      ev(1'b1, 3);
      rdc(IDX_IRQ_FLAG, 32'h1);
      rdc(IDX_RUN_STATE, 32'h0);
      wr(IDX_CONTROL_SECOND, 8'h01);
      wr(IDX_EVENT_CONTROL, 8'h11);
      ev(1'b0, 3);
      rdc(IDX_RUN_STATE, 32'h1);
      ev(1'b1, 3);
      rdc(IDX_RUN_STATE, 32'h0);
      wr(IDX_COMPARE_LO, 8'h20);
      wr(IDX_COMPARE_HI, 8'h00);
      wr(IDX_CONTROL_SECOND, 8'h06);
      wr(IDX_EVENT_CONTROL, 8'h01);
      wr(IDX_IRQ_FLAG, 8'h01);
      ev(1'b0, 3);
      rdc(IDX_RUN_STATE, 32'h0);
      ev(1'b1, 3);
      rdc(IDX_RUN_STATE, 32'h1);
      repeat (40) @(posedge sys_clk);
      rdc(IDX_IRQ_FLAG, 32'h1);
      rdc(IDX_RUN_STATE, 32'h0);
      wr(IDX_CONTROL_SECOND, 8'h07);
      wr(IDX_COMPARE_LO, 8'h0f);
      wr(IDX_COMPARE_HI, 8'h05);
      rdc(IDX_COMPARE_HI, 32'h05);
      wr(IDX_IRQ_FLAG, 8'h01);
      repeat (300) @(posedge sys_clk);
      rdc(IDX_IRQ_FLAG, 32'h1);
      complete_run();
   end

   initial begin
      #200000;
      failures++;
      complete_run();
   end
endmodule : timer_b_mode_event_capture_regs_tb
